/* design/gdio_port.sv */
// Sixteen-in, sixteen-out filtered digital port with edge interrupts
// Functional notes
// - Sixteen input channels, each usable as an interrupt source.
// - Sixteen output channels set by software over the host side.
// - Per-line interrupt enable and selectable trigger edge.
// - Selected edge on an enabled filtered input raises an interrupt.
// - All sixteen interrupt sources merge onto one interrupt line.
// - Digital filter rejects noise pulses and chatter on every input.
// - Negative logic: data 1 means low pin level, 0 means high.
// - All outputs forced off from reset until software writes.
`default_nettype none
module gdio_port
  import gdio_pkg::*;
#(
  parameter int CHANNELS = GDIO_CHANNELS,
  parameter int FILT_CYCLES = GDIO_FILT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Input pins, raw from isolators
  input wire logic [CHANNELS-1:0] in_pin,
  // Output pins, high level means switch off
  output logic [CHANNELS-1:0] out_pin,
  // Host side: output data
  input wire logic out_wr,
  input wire logic [CHANNELS-1:0] out_wdata,
  // Host side: interrupt setup
  input wire logic cfg_wr,
  input wire logic [CHANNELS-1:0] cfg_irq_en,
  input wire logic [CHANNELS-1:0] cfg_edge,
  // Host side: clear, one bit per source
  input wire logic irq_clr,
  input wire logic [CHANNELS-1:0] irq_clr_mask,
  // Host side: status
  output logic [CHANNELS-1:0] in_data,
  output logic [CHANNELS-1:0] irq_pending,
  output logic irq_out
);
  localparam int CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] FILT_LAST = CW'(FILT_CYCLES - 1);

  logic [CHANNELS-1:0] sync1;
  logic [CHANNELS-1:0] sync2;
  logic [CHANNELS-1:0] filt;
  logic [CHANNELS-1:0] filt_d;
  logic [CHANNELS-1:0] irq_en;
  logic [CHANNELS-1:0] edge_sel;
  logic [CHANNELS-1:0] out_data;
  logic [CHANNELS-1:0] rise;
  logic [CHANNELS-1:0] fall;
  logic [CHANNELS-1:0] hit;
  logic [CHANNELS-1:0] next_pending;
  logic [CHANNELS-1:0] clr_bits;

  // Pins cross in from the isolators asynchronously
  // Reset to the idle pin level so no false edge follows reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1 <= GDIO_OUT_RESET;
      sync2 <= GDIO_OUT_RESET;
    end else begin
      sync1 <= in_pin;
      sync2 <= sync1;
    end
  end

  // per-channel filter
  // A level must hold for FILT_CYCLES before it is accepted; shorter pulses vanish
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_filt
      logic [CW-1:0] cnt;
      wire differs = (sync2[g] != filt[g]);
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          cnt <= '0;
          filt[g] <= 1'b1;
        end else if (!differs) begin
          cnt <= '0;
        end else if (cnt == FILT_LAST) begin
          cnt <= '0;
          filt[g] <= sync2[g];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate

  // data bit is the inverted pin level
  // all sixteen channels feed edge detection
  assign rise = ~filt & filt_d;
  assign fall = filt & ~filt_d;
  // enable and edge choice per line
  // edge select: rise means data 0 to 1, pin high to low
  assign hit = irq_en & ((edge_sel & rise) | (~edge_sel & fall));
  // Mask only counts while the clear strobe is high
  assign clr_bits = irq_clr ? irq_clr_mask : GDIO_ZERO;
  // set wins over a clear in the same cycle
  assign next_pending = (irq_pending & ~clr_bits) | hit;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      filt_d <= GDIO_OUT_RESET;
      in_data <= GDIO_ZERO;
      irq_pending <= GDIO_ZERO;
      irq_out <= 1'b0;
    end else begin
      filt_d <= filt;
      in_data <= ~filt;
      irq_pending <= next_pending;
      // merge all sources onto one line
      irq_out <= |next_pending;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_en <= GDIO_ZERO;
      edge_sel <= GDIO_ZERO;
    end else if (cfg_wr) begin
      irq_en <= cfg_irq_en;
      edge_sel <= cfg_edge;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_data <= GDIO_ZERO;
      out_pin <= GDIO_OUT_RESET;
    end else begin
      if (out_wr) begin
        out_data <= out_wdata;
      end
      // Write bypasses out_data so the pin follows one edge after the strobe
      // data 1 drives the pin low
      out_pin <= out_wr ? ~out_wdata : ~out_data;
    end
  end

  // Assertions
  sequence s_rise_hit(int i);
    irq_en[i] && edge_sel[i] && rise[i];
  endsequence

  a_out_negative: assert property (@(posedge sys_clk) disable iff (sys_rst)
    out_wr |=> out_pin == ~$past(out_wdata))
    else $error("output pin not inverted data");
  a_out_reset_off: assert property (@(posedge sys_clk)
    sys_rst |=> out_pin == GDIO_OUT_RESET)
    else $error("outputs not off after reset");
  a_out_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !out_wr && !$past(out_wr) |-> $stable(out_pin))
    else $error("output changed without write");
  a_irq_merge: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_out == (|irq_pending))
    else $error("interrupt line does not match pending");
  a_irq_rise0: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_rise_hit(0) |=> irq_pending[0] && irq_out)
    else $error("rising edge interrupt missed");
  a_irq_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !irq_en[1] && !irq_pending[1] |=> !irq_pending[1])
    else $error("disabled line raised interrupt");
  a_irq_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_pending[2] && !irq_clr |=> irq_pending[2])
    else $error("pending bit dropped without clear");
  a_filt_glitch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(filt[0]) |-> $past(sync2[0]) == filt[0])
    else $error("filter accepted unsettled level");
  a_in_negative: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 in_data == ~$past(filt))
    else $error("input data not inverted");

  // Filter check helper: run length of the synchronised level on channel 0
  // Kept apart from the filter counter so a broken filter cannot hide itself
  logic [CW-1:0] run0;
  logic sync2_d0;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run0 <= '0;
      sync2_d0 <= 1'b1;
    end else begin
      sync2_d0 <= sync2[0];
      if (sync2[0] != sync2_d0) begin
        run0 <= '0;
      end else if (run0 != FILT_LAST) begin
        run0 <= run0 + 1'b1;
      end
    end
  end

  a_filt_steady: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(filt[0]) |-> run0 == FILT_LAST && sync2_d0 == filt[0])
    else $error("filter passed a short pulse");

  // Setup and reset state
  a_cfg_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cfg_wr |=> irq_en == $past(cfg_irq_en) && edge_sel == $past(cfg_edge))
    else $error("interrupt setup not loaded");
  a_reset_clear: assert property (@(posedge sys_clk)
    sys_rst |=> irq_pending == GDIO_ZERO && !irq_out && in_data == GDIO_ZERO)
    else $error("status not cleared by reset");

  // Per-channel interrupt checks
  for (g = 0; g < CHANNELS; g++) begin : g_irq_chk
    a_irq_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
      irq_en[g] && !edge_sel[g] && fall[g] |=> irq_pending[g] && irq_out)
      else $error("falling edge interrupt missed");
    a_irq_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      irq_clr && irq_clr_mask[g] && !hit[g] |=> !irq_pending[g])
      else $error("pending bit survived its clear");
    a_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
      hit[g] |=> irq_pending[g])
      else $error("new interrupt lost");
  end
endmodule : gdio_port
`default_nettype wire

/* design/gdio_pkg.sv */
// Package: constants for the filtered digital I/O port block
`default_nettype none
package gdio_pkg;
  localparam int GDIO_CHANNELS = 16;
  localparam int GDIO_CLK_HZ = 25_000_000;
  // Filter settle time in microseconds
  localparam int GDIO_FILT_TIME_US = 10;
  localparam int GDIO_FILT_CYCLES = (GDIO_FILT_TIME_US * (GDIO_CLK_HZ / 1_000_000));
  localparam logic [15:0] GDIO_OUT_RESET = 16'hFFFF;
  localparam logic [15:0] GDIO_ZERO = 16'h0000;
  localparam logic GDIO_EDGE_FALL = 1'b0;
  localparam logic GDIO_EDGE_RISE = 1'b1;
endpackage : gdio_pkg
`default_nettype wire

/* tb/gdio_host.sv */
// Host model that acknowledges pending interrupts
`default_nettype none
module gdio_host (
  // Clock
  input wire logic sys_clk,
  // Interrupt status
  input wire logic irq_out,
  input wire logic [15:0] irq_pending,
  input wire logic ack_en,
  // Clear strobe
  output logic irq_clr,
  output logic [15:0] irq_clr_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  wire go = ack_en && irq_out && !irq_clr;
  // clears every pending source
  // Idle mask is inverted so a stale mask never matches
  always @(negedge sys_clk) begin
    irq_clr <= go;
    irq_clr_mask <= go ? irq_pending : ~irq_pending;
  end
endmodule : gdio_host
`default_nettype wire

/* tb/gdio_port_test.sv */
// Self-checking bench for the filtered digital port
`default_nettype none
module gdio_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, sys_rst = 1, out_wr = 0, cfg_wr = 0, ack_en = 0;
  logic [15:0] in_pin = 16'hFFFF, out_wdata = 16'h0000, en = 16'h0000, edg = 16'h0000;
  localparam int FILT = 4;
  logic [15:0] dm = 16'h0000, pm, w, ow;
  wire irq_clr, irq_out;
  wire [15:0] out_pin, in_data, irq_pending, irq_clr_mask;
  int err_total = 0, cmp_count = 0, i;
  gdio_port #(.CHANNELS(16), .FILT_CYCLES(FILT)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .in_pin(in_pin),
    .out_pin(out_pin), .out_wr(out_wr), .out_wdata(out_wdata), .cfg_wr(cfg_wr), .cfg_irq_en(en),
    .cfg_edge(edg), .irq_clr(irq_clr), .irq_clr_mask(irq_clr_mask), .in_data(in_data),
    .irq_pending(irq_pending), .irq_out(irq_out));
  gdio_host host_u (.sys_clk(sys_clk), .irq_out(irq_out), .irq_pending(irq_pending), .ack_en(ack_en),
    .irq_clr(irq_clr), .irq_clr_mask(irq_clr_mask));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input logic [15:0] v);
    @(negedge sys_clk) in_pin = v;
    repeat (16) @(negedge sys_clk);
  endtask : settle
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // Run needs about 350 cycles; allow over ten times that
  initial begin
    #160000 err_total++;
    report_and_stop();
  end
  initial begin
    w = 16'($urandom(72989));
    repeat (4) @(negedge sys_clk);
    sys_rst = 0;
    chk(out_pin, 16'hFFFF);
    chk(irq_pending, 16'h0000);
    $display("Test reset done");
    for (i = 0; i < 8; i++) begin
      ow = 16'($urandom);
      @(negedge sys_clk) {out_wr, out_wdata, cfg_wr} = {1'b1, ow, 1'b1};
      {en, edg} = {16'($urandom), 16'($urandom)};
      @(negedge sys_clk) {out_wr, cfg_wr} = 2'b00;
      chk(out_pin, ~ow);
      // Glitch one cycle shorter than the filter window
      @(negedge sys_clk) in_pin = 16'($urandom);
      repeat (FILT - 1) @(negedge sys_clk);
      in_pin = ~dm;
      repeat (16) @(negedge sys_clk);
      chk(in_data, dm);
      chk(irq_pending, 16'h0000);
      w = 16'($urandom);
      pm = en & ((edg & w & ~dm) | (~edg & ~w & dm));
      settle(~w);
      chk(in_data, w);
      chk(irq_pending, pm);
      chk({15'h0000, irq_out}, {15'h0000, |pm});
      chk(out_pin, ~ow);
      dm = w;
      ack_en <= 1'b1;
      repeat (4) @(negedge sys_clk);
      ack_en <= 1'b0;
      chk(irq_pending, 16'h0000);
      chk({15'h0000, irq_out}, 16'h0000);
      $display("Test %0d done", i);
    end
    report_and_stop();
  end
endmodule : gdio_port_test
`default_nettype wire
